// >>> hw/rpmc_pkg.sv
// Purpose: shared constants for reset and power mode control
// Assumes: 8-bit special function register port, 20 MHz clock
// Notes: offsets are register addresses on the cpu register port
package rpmc_pkg;
  localparam logic [7:0] ADDR_POWER_CONTROL = 8'h87;
  localparam logic [7:0] ADDR_RESET_CAUSE = 8'hb1;
  localparam logic [7:0] ADDR_POWER_DOWN_SEL = 8'hb6;
  localparam logic [7:0] ADDR_SLOW_IF_CTRL = 8'had;
  // power control field positions
  localparam int PC_IDLE_BIT = 0;
  localparam int PC_STOP_BIT = 1;
  localparam int PC_FLAG0_BIT = 2;
  localparam int PC_FLAG1_BIT = 3;
  localparam int PC_DOUBLER_BIT = 7;
  localparam logic [7:0] PC_WRITE_MASK = 8'h8f;
  localparam logic [7:0] PC_RESET = 8'h00;
  // reset cause field positions
  localparam int RC_CAUSE_BIT = 0;
  localparam int RC_ROM_VEC_BIT = 1;
  localparam logic [1:0] RC_RESET = 2'h2;
  localparam int SLOW_BUSY_BIT = 4;
  localparam logic [2:0] PD_RESET = 3'h0;
  localparam logic [2:0] PD_NORMAL = 3'h0;
  localparam logic [2:0] PD_LIGHT = 3'h1;
  localparam logic [2:0] PD_MODERATE = 3'h2;
  localparam logic [2:0] PD_STANDBY = 3'h3;
  localparam int PD_DEEP_BIT = 2;
  localparam logic [15:0] VEC_NORMAL = 16'h0000;
  localparam logic [15:0] VEC_ROM = 16'h8000;
  // startup timing
  localparam int CLK_HZ = 20000000;
  localparam int CRYSTAL_CLOCK_SETTLE_CYCLES = 2500;
  localparam real XO_STARTUP_MS = 3.0;
  localparam int XO_STARTUP_CYCLES = int'(XO_STARTUP_MS * CLK_HZ / 1000.0);
  localparam int SLOW_EDGES_NEEDED = 1;
  typedef enum logic [4:0] {
    SEQ_HOLD = 5'b00001,
    SEQ_OSC = 5'b00010,
    SEQ_INIT = 5'b00100,
    SEQ_SETTLE = 5'b01000,
    SEQ_RUN = 5'b10000
  } rpmc_seq_type;
  typedef enum logic [3:0] {
    PM_ACTIVE = 4'b0001,
    PM_IDLE = 4'b0010,
    PM_STOP = 4'b0100,
    PM_DOWN = 4'b1000
  } rpmc_mode_type;
endpackage

// >>> hw/rpmc_sync.sv
// Purpose: two flip-flop synchroniser for a group of levels
// Assumes: inputs come from outside the clk domain
// Notes: first stage is read only by the second
`timescale 1ns/10ps
module rpmc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage1;
  // plain double flop, reset to zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage1 <= '0;
      dout <= '0;
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule

// >>> hw/rpmc_counter.sv
// Purpose: startup delay counter, counts fast cycles and slow edges
// Assumes: slow clock level already synchronised
// Notes: done when both counts reached
`timescale 1ns/10ps
module rpmc_counter #(
  parameter int FAST_CYCLES = 2500,
  parameter int SLOW_EDGES = 1,
  parameter int CW = 20
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic slowLevel,
  output logic done
);
  logic [CW-1:0] fastCount;
  logic [3:0] slowCount;
  logic slowPrev;
  logic running;
  // fast and slow counts run together; delay is the longer of the two
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fastCount <= '0;
      slowCount <= 4'h0;
      slowPrev <= 1'b0;
      running <= 1'b0;
      done <= 1'b0;
    end else begin
      slowPrev <= slowLevel;
      done <= 1'b0;
      if (start) begin
        fastCount <= '0;
        slowCount <= 4'h0;
        running <= 1'b1;
      end else if (running) begin
        if (fastCount < CW'(FAST_CYCLES)) begin
          fastCount <= fastCount + 1'b1;
        end
        if (slowLevel && !slowPrev && slowCount < 4'(SLOW_EDGES)) begin
          slowCount <= slowCount + 4'h1;
        end
        if (fastCount >= CW'(FAST_CYCLES) && slowCount >= 4'(SLOW_EDGES)) begin
          running <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end
endmodule

// >>> hw/rpmc_control.sv
// Purpose: reset sequencing, reset cause, idle, stop and power down control
// Assumes: cpu register port on clk; power-on and watchdog sources are async pins
// Notes: cpuHold suspends the core; wakeups and slow clock are synchronised here
`timescale 1ns/10ps
module rpmc_control
  import rpmc_pkg::*;
#(
  parameter int XO_STARTUP = XO_STARTUP_CYCLES,
  parameter int SETTLE = CRYSTAL_CLOCK_SETTLE_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic powerOnReset,
  input wire logic watchdogExpired,
  input wire logic slowClock,
  input wire logic pinWakeFiltered,
  input wire logic timerWake,
  input wire logic slowIfBusy,
  input wire logic interruptPending,
  input wire logic instrDone,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  output logic chipResetActive,
  output logic oscEnable,
  output logic sfrInit,
  output logic cpuHold,
  output logic fetchStart,
  output logic [15:0] resetVector,
  output logic bootLoaderStart,
  output logic baudRateDoubler,
  output logic [2:0] powerDownLevel,
  output logic crystalOff,
  output logic slowFromLowPower
);
  logic [2:0] syncOut;
  logic porSync;
  logic wdSync;
  logic slowLevel;
  logic [1:0] wakeSync;
  logic [1:0] wakeRaw;
  logic wakeAny;
  rpmc_seq_type seqState;
  rpmc_mode_type modeState;
  logic [7:0] powerControl;
  logic [1:0] resetCause;
  logic [2:0] powerDownSel;
  logic lastWasPor;
  logic xoRunning;
  logic [22:0] oscCount;
  logic settleStart;
  logic settleDone;
  logic resetEvent;
  logic wdPrev;
  logic pendingIdle;
  logic pendingStop;
  logic pendingDown;

  // two reset sources only, both synchronised
  rpmc_sync #(.WIDTH(3)) u_sync_rst (
    .clk(clk),
    .rst(rst),
    .din({powerOnReset, watchdogExpired, slowClock}),
    .dout(syncOut)
  );
  assign porSync = syncOut[2];
  assign wdSync = syncOut[1];
  assign slowLevel = syncOut[0];

  // wake pin arrives after its debounce filter, so we stay down meanwhile
  assign wakeRaw = {pinWakeFiltered, timerWake};
  rpmc_sync #(.WIDTH(2)) u_sync_wake (
    .clk(clk),
    .rst(rst),
    .din(wakeRaw),
    .dout(wakeSync)
  );
  assign wakeAny = |wakeSync;

  // watchdog acts on its rising edge so a held expiry restarts only once
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wdPrev <= 1'b0;
    end else begin
      wdPrev <= wdSync;
    end
  end
  assign resetEvent = porSync || (wdSync && !wdPrev);

  // slow clock edges and crystal cycles, counted together, make the settle delay; the longer count ends it
  rpmc_counter #(.FAST_CYCLES(SETTLE), .SLOW_EDGES(SLOW_EDGES_NEEDED), .CW(20)) u_settle (
    .clk(clk),
    .rst(rst),
    .start(settleStart),
    .slowLevel(slowLevel),
    .done(settleDone)
  );

  // reset sequence hold, oscillator, init, settle, run
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      seqState <= SEQ_HOLD;
      oscCount <= 23'h000000;
      settleStart <= 1'b0;
    end else begin
      settleStart <= 1'b0;
      if (porSync) begin
        seqState <= SEQ_HOLD;
      end else if (resetEvent) begin
        // skip oscillator wait when crystal already running
        seqState <= xoRunning ? SEQ_INIT : SEQ_OSC;
        oscCount <= 23'h000000;
      end else begin
        case (seqState)
          SEQ_HOLD: begin
            seqState <= SEQ_OSC;
            oscCount <= 23'h000000;
          end
          SEQ_OSC: begin
            if (oscCount >= 23'(XO_STARTUP)) begin
              seqState <= SEQ_INIT;
            end else begin
              oscCount <= oscCount + 23'h000001;
            end
          end
          SEQ_INIT: begin
            seqState <= SEQ_SETTLE;
            settleStart <= 1'b1;
          end
          SEQ_SETTLE: begin
            if (settleDone) begin
              seqState <= SEQ_RUN;
            end
          end
          SEQ_RUN: seqState <= SEQ_RUN;
          default: seqState <= SEQ_HOLD;
        endcase
      end
    end
  end

  // crystal state tracks oscillator phase and deep power down
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      xoRunning <= 1'b0;
    end else if (porSync) begin
      xoRunning <= 1'b0;
    end else if (seqState == SEQ_INIT) begin
      xoRunning <= 1'b1;
    end else if (modeState == PM_DOWN && powerDownSel[PD_DEEP_BIT]) begin
      xoRunning <= 1'b0;
    end
  end

  // cause bit cleared by power-on, set by watchdog
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      resetCause <= RC_RESET;
      lastWasPor <= 1'b1;
    end else if (porSync) begin
      resetCause <= RC_RESET;
      lastWasPor <= 1'b1;
    end else if (resetEvent) begin
      // cause bit marks non power-on reset
      resetCause <= RC_RESET | 2'h1;
      lastWasPor <= 1'b0;
    end else if (regWrite && regAddr == ADDR_RESET_CAUSE && seqState == SEQ_RUN) begin
      // software may clear cause to force reboot
      resetCause <= regWdata[1:0];
    end
  end

  // doubler and general flags are plain storage, reserved bits dropped
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      powerControl <= PC_RESET;
    end else if (resetEvent || seqState == SEQ_INIT) begin
      powerControl <= PC_RESET;
    end else if (regWrite && regAddr == ADDR_POWER_CONTROL && seqState == SEQ_RUN) begin
      powerControl <= regWdata & PC_WRITE_MASK;
    end else if (modeState == PM_IDLE && interruptPending) begin
      powerControl[PC_IDLE_BIT] <= 1'b0;
    end
  end

  // selector written, cleared by wake or reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      powerDownSel <= PD_RESET;
    end else if (resetEvent || seqState == SEQ_INIT) begin
      powerDownSel <= PD_RESET;
    end else if (regWrite && regAddr == ADDR_POWER_DOWN_SEL && seqState == SEQ_RUN) begin
      // software checks busy first; we do not guard it
      powerDownSel <= regWdata[2:0];
    end else if (modeState == PM_DOWN && wakeAny) begin
      powerDownSel <= PD_NORMAL;
    end
  end

  // mode requests wait for the writing instruction to complete
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pendingIdle <= 1'b0;
      pendingStop <= 1'b0;
      pendingDown <= 1'b0;
    end else if (resetEvent || instrDone) begin
      pendingIdle <= 1'b0;
      pendingStop <= 1'b0;
      pendingDown <= 1'b0;
    end else if (regWrite && seqState == SEQ_RUN) begin
      if (regAddr == ADDR_POWER_CONTROL) begin
        pendingIdle <= regWdata[PC_IDLE_BIT];
        pendingStop <= regWdata[PC_STOP_BIT];
      end
      if (regAddr == ADDR_POWER_DOWN_SEL) begin
        pendingDown <= |regWdata[2:0];
      end
    end
  end

  // power mode machine; stop ignores interrupts and wakes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      modeState <= PM_ACTIVE;
    end else if (resetEvent || seqState != SEQ_RUN) begin
      // watchdog ends idle, stop and power down
      // watchdog exits power down through init and settle; the oscillator wait comes first only after deep
      modeState <= PM_ACTIVE;
    end else begin
      case (modeState)
        PM_ACTIVE: begin
          // enter after the setting instruction completes
          if (instrDone && pendingDown) begin
            modeState <= PM_DOWN;
          end else if (instrDone && pendingStop) begin
            modeState <= PM_STOP;
          end else if (instrDone && pendingIdle) begin
            modeState <= PM_IDLE;
          end
        end
        PM_IDLE: begin
          if (interruptPending) begin
            modeState <= PM_ACTIVE;
          end
        end
        PM_STOP: modeState <= PM_STOP;
        PM_DOWN: begin
          // core resumes, its interrupt logic services the wake
          if (wakeAny) begin
            modeState <= PM_ACTIVE;
          end
        end
        default: modeState <= PM_ACTIVE;
      endcase
    end
  end

  // registered outputs toward core and analog blocks
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      chipResetActive <= 1'b1;
      oscEnable <= 1'b0;
      sfrInit <= 1'b0;
      cpuHold <= 1'b1;
      fetchStart <= 1'b0;
      resetVector <= VEC_ROM;
      bootLoaderStart <= 1'b0;
      baudRateDoubler <= 1'b0;
      powerDownLevel <= PD_NORMAL;
      crystalOff <= 1'b0;
      slowFromLowPower <= 1'b0;
    end else begin
      chipResetActive <= seqState != SEQ_RUN;
      oscEnable <= seqState != SEQ_HOLD &&
        !(modeState == PM_DOWN && powerDownSel[PD_DEEP_BIT]);
      sfrInit <= seqState == SEQ_INIT;
      // CPU clock keeps running in idle; only fetch is held
      cpuHold <= seqState != SEQ_RUN || modeState != PM_ACTIVE;
      fetchStart <= seqState == SEQ_SETTLE && settleDone;
      resetVector <= resetCause[RC_ROM_VEC_BIT] ? VEC_ROM : VEC_NORMAL;
      // loader only when lastWasPor shows the last reset was power-on
      bootLoaderStart <= seqState == SEQ_SETTLE && settleDone && lastWasPor;
      baudRateDoubler <= powerControl[PC_DOUBLER_BIT];
      // decode level; deep ignores low bits
      if (modeState != PM_DOWN) begin
        powerDownLevel <= PD_NORMAL;
      end else if (powerDownSel[PD_DEEP_BIT]) begin
        powerDownLevel <= 3'h4;
      end else begin
        powerDownLevel <= powerDownSel;
      end
      crystalOff <= modeState == PM_DOWN && powerDownSel[PD_DEEP_BIT];
      slowFromLowPower <= modeState == PM_DOWN &&
        (powerDownSel[PD_DEEP_BIT] || powerDownSel == PD_STANDBY);
    end
  end

  // register read data
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      regRdata <= 8'h00;
    end else if (regRead) begin
      case (regAddr)
        ADDR_POWER_CONTROL: regRdata <= powerControl;
        ADDR_RESET_CAUSE: regRdata <= {6'h00, resetCause};
        // selector read gives slow clock level
        ADDR_POWER_DOWN_SEL: regRdata <= {7'h00, slowLevel};
        // busy bit reflects slow interface transfer
        ADDR_SLOW_IF_CTRL: regRdata <= {3'h0, slowIfBusy, 4'h0};
        default: regRdata <= 8'h00;
      endcase
    end
  end

  stop_sticky_a: assert property (@(posedge clk) disable iff (rst)
    (modeState == PM_STOP && !resetEvent) |=> modeState == PM_STOP)
    else $error("stop mode left without reset");
  por_cause_a: assert property (@(posedge clk) disable iff (rst)
    porSync |=> resetCause == RC_RESET)
    else $error("cause not cleared by power-on");
  wd_cause_a: assert property (@(posedge clk) disable iff (rst)
    (!porSync && resetEvent) |=> resetCause[RC_CAUSE_BIT])
    else $error("cause not set by watchdog");
  idle_wake_a: assert property (@(posedge clk) disable iff (rst)
    (modeState == PM_IDLE && interruptPending && !resetEvent && seqState == SEQ_RUN)
      |=> modeState == PM_ACTIVE ##1 !cpuHold)
    else $error("idle not ended by interrupt");
  down_wake_a: assert property (@(posedge clk) disable iff (rst)
    (modeState == PM_DOWN && wakeAny && !resetEvent && seqState == SEQ_RUN)
      |=> powerDownSel == PD_NORMAL && modeState == PM_ACTIVE)
    else $error("wake did not clear power down");
  wd_exit_a: assert property (@(posedge clk) disable iff (rst)
    resetEvent |=> modeState == PM_ACTIVE ##1 cpuHold)
    else $error("reset did not end low power mode");
  vec_sel_a: assert property (@(posedge clk) disable iff (rst)
    resetCause[RC_ROM_VEC_BIT] |=> resetVector == VEC_ROM)
    else $error("vector does not follow select bit");
  deep_level_a: assert property (@(posedge clk) disable iff (rst)
    (modeState == PM_DOWN && powerDownSel[PD_DEEP_BIT]) |=> crystalOff)
    else $error("deep power down left crystal on");
  settle_min_a: assert property (@(posedge clk) disable iff (rst)
    settleStart |=> !fetchStart [*3])
    else $error("fetch began before settle delay");
endmodule

// >>> sim/rpmc_far_model.sv
// Purpose: far side model, slow clock blocks, busy flag and wakeup sources
// Assumes: requests from the bench arrive on clk rising edges
// Notes: the slow clock runs free, being an always-on oscillator
`timescale 1ns/10ps
module rpmc_far_model #(
  parameter int SLOW_HALF = 20,
  parameter int DEBOUNCE = 8,
  parameter int BUSY_LEN = 12
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic pinReq,
  input wire logic timerReq,
  input wire logic xferStart,
  output logic slowClock,
  output logic pinWakeFiltered,
  output logic timerWake,
  output logic slowIfBusy
);
  int slowCnt;
  int debCnt;
  int busyCnt;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      slowCnt <= 0;
      slowClock <= 1'b0;
    end else if (slowCnt == SLOW_HALF - 1) begin
      slowCnt <= 0;
      slowClock <= ~slowClock;
    end else begin
      slowCnt <= slowCnt + 1;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst || !pinReq) begin
      debCnt <= 0;
      pinWakeFiltered <= 1'b0;
    end else if (debCnt == DEBOUNCE) begin
      pinWakeFiltered <= 1'b1;
    end else begin
      debCnt <= debCnt + 1;
    end
  end
  // timer wake is a plain level, no filter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timerWake <= 1'b0;
    end else begin
      timerWake <= timerReq;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busyCnt <= 0;
    end else if (xferStart) begin
      busyCnt <= BUSY_LEN;
    end else if (busyCnt != 0) begin
      busyCnt <= busyCnt - 1;
    end
  end
  assign slowIfBusy = (busyCnt != 0);
endmodule

// >>> sim/tb_top.sv
// Purpose: self-checking bench for reset and power mode control
// Assumes: short startup counts so a reset takes tens of cycles
// Notes: read answers are matched against a queue of notes by a monitor
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin fails++; \
  $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module tb_top
  import rpmc_pkg::*;
;
  localparam int DEB = 8;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic powerOnReset = 1'b1;
  logic watchdogExpired = 1'b0;
  logic interruptPending = 1'b0;
  logic instrDone = 1'b0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWdata = 8'h00;
  logic pinReq = 1'b0;
  logic timerReq = 1'b0;
  logic xferStart = 1'b0;
  logic slowClock, pinWakeFiltered, timerWake, slowIfBusy;
  logic chipResetActive, oscEnable, sfrInit, cpuHold, fetchStart;
  logic bootLoaderStart, baudRateDoubler, crystalOff, slowFromLowPower;
  logic [7:0] regRdata;
  logic [15:0] resetVector;
  logic [2:0] powerDownLevel;
  logic rdLate = 1'b0;
  logic sawInit = 1'b0;
  logic [15:0] note;
  logic [15:0] rdQ[$];
  int fails = 0;
  int compares = 0;

  always #25 clk = ~clk;

  rpmc_control #(.XO_STARTUP(20), .SETTLE(10)) u_rpmc_control (
    .clk(clk), .rst(rst), .powerOnReset(powerOnReset), .watchdogExpired(watchdogExpired),
    .slowClock(slowClock), .pinWakeFiltered(pinWakeFiltered), .timerWake(timerWake),
    .slowIfBusy(slowIfBusy), .interruptPending(interruptPending), .instrDone(instrDone),
    .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
    .regRdata(regRdata), .chipResetActive(chipResetActive), .oscEnable(oscEnable),
    .sfrInit(sfrInit), .cpuHold(cpuHold), .fetchStart(fetchStart),
    .resetVector(resetVector), .bootLoaderStart(bootLoaderStart),
    .baudRateDoubler(baudRateDoubler), .powerDownLevel(powerDownLevel),
    .crystalOff(crystalOff), .slowFromLowPower(slowFromLowPower));

  rpmc_far_model #(.DEBOUNCE(DEB)) u_rpmc_far_model (
    .clk(clk), .rst(rst), .pinReq(pinReq), .timerReq(timerReq), .xferStart(xferStart),
    .slowClock(slowClock), .pinWakeFiltered(pinWakeFiltered), .timerWake(timerWake),
    .slowIfBusy(slowIfBusy));

  // read answer lands one edge after the request
  always @(posedge clk) rdLate <= regRead;
  // oldest note pairs with each answer; mask hides undefined bits
  always @(negedge clk) begin
    if (sfrInit === 1'b1) sawInit = 1'b1;
    if (rdLate) begin
      note = rdQ.pop_front();
      `CHK("regRdata", note[15:8] & note[7:0], regRdata & note[7:0])
    end
  end

  task automatic end_sim();
    if (fails == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] ex, input logic [7:0] m);
    rdQ.push_back({ex, m});
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  // the instruction that wrote a mode bit completes
  task automatic instr();
    @(posedge clk);
    instrDone <= 1'b1;
    @(posedge clk);
    instrDone <= 1'b0;
  endtask
  task automatic waitHold(input logic lvl, input int lim);
    int n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (cpuHold !== lvl && n < lim);
    `CHK("cpuHold", lvl, cpuHold)
  endtask
  // bounded wait for the fetch pulse, then inspect what it carries
  task automatic waitFetch(input logic [15:0] v, input logic b);
    int n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (fetchStart !== 1'b1 && n < 300);
    `CHK("fetchStart", 1'b1, fetchStart)
    `CHK("sfrInit seen", 1'b1, sawInit)
    `CHK("resetVector", v, resetVector)
    `CHK("bootLoaderStart", b, bootLoaderStart)
    sawInit = 1'b0;
    @(negedge clk);
    `CHK("chipResetActive", 1'b0, chipResetActive)
  endtask
  task automatic wdog();
    @(posedge clk);
    watchdogExpired <= 1'b1;
    repeat (4) @(posedge clk);
    watchdogExpired <= 1'b0;
  endtask
  task automatic enterPd(input logic [2:0] c);
    while (slowIfBusy !== 1'b0) @(posedge clk);
    wr(ADDR_POWER_DOWN_SEL, {5'h00, c});
    instr();
    waitHold(1'b1, 10);
    `CHK("powerDownLevel", c[2] ? 3'h4 : c, powerDownLevel)
    `CHK("crystalOff", c[2], crystalOff)
    `CHK("oscEnable", !c[2], oscEnable)
    `CHK("slowFromLowPower", c >= 3'h3, slowFromLowPower)
  endtask
  task automatic pdown(input logic [2:0] c, input logic pin);
    enterPd(c);
    @(posedge clk);
    if (pin) begin
      pinReq <= 1'b1;
      repeat (DEB) @(negedge clk);
      `CHK("cpuHold debounce", 1'b1, cpuHold)
    end else begin
      timerReq <= 1'b1;
    end
    waitHold(1'b0, 30);
    `CHK("powerDownLevel", 3'h0, powerDownLevel)
    @(posedge clk);
    pinReq <= 1'b0;
    timerReq <= 1'b0;
  endtask

  // a hang counts as a mismatch and ends the run the normal way
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    end_sim();
  end

  initial begin
    int v;
    v = $urandom(32'hdd67f2ac);
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    powerOnReset <= 1'b0;
    waitFetch(VEC_ROM, 1'b1);
    rd(ADDR_RESET_CAUSE, 8'h02, 8'h03);
    rd(ADDR_POWER_CONTROL, PC_RESET, 8'h8f);
    rd(8'h00, 8'h00, 8'hff);
    // random flags and doubler, reserved bits written too
    repeat (4) begin
      v = $urandom();
      wr(ADDR_POWER_CONTROL, v[7:0] & 8'hfc);
      rd(ADDR_POWER_CONTROL, v[7:0], 8'h8c);
      @(negedge clk);
      `CHK("baudRateDoubler", v[7], baudRateDoubler)
    end
    @(posedge clk);
    xferStart <= 1'b1;
    @(posedge clk);
    xferStart <= 1'b0;
    rd(ADDR_SLOW_IF_CTRL, 8'h10, 8'h10);
    repeat (14) @(posedge clk);
    rd(ADDR_SLOW_IF_CTRL, 8'h00, 8'h10);
    // read well away from a slow edge so the sync has settled
    repeat (2) begin
      @(slowClock);
      repeat (4) @(posedge clk);
      rd(ADDR_POWER_DOWN_SEL, {7'h00, slowClock}, 8'h01);
    end
    wr(ADDR_POWER_CONTROL, 8'h01);
    instr();
    waitHold(1'b1, 10);
    @(posedge clk);
    interruptPending <= 1'b1;
    waitHold(1'b0, 10);
    @(posedge clk);
    interruptPending <= 1'b0;
    rd(ADDR_POWER_CONTROL, 8'h00, 8'h01);
    // stop with both flags set; an interrupt must not end it
    wr(ADDR_POWER_CONTROL, 8'h0e);
    instr();
    waitHold(1'b1, 10);
    @(posedge clk);
    interruptPending <= 1'b1;
    repeat (40) @(negedge clk);
    `CHK("cpuHold stop", 1'b1, cpuHold)
    @(posedge clk);
    interruptPending <= 1'b0;
    wdog();
    // crystal still running, so init follows at once
    @(negedge clk);
    `CHK("sfrInit skip", 1'b1, sfrInit)
    waitFetch(VEC_ROM, 1'b0);
    rd(ADDR_RESET_CAUSE, 8'h03, 8'h03);
    rd(ADDR_POWER_CONTROL, 8'h00, 8'h8f);
    // both cause bits cleared: reboot request and low vector
    wr(ADDR_RESET_CAUSE, 8'h00);
    rd(ADDR_RESET_CAUSE, 8'h00, 8'h03);
    @(negedge clk);
    `CHK("resetVector low", VEC_NORMAL, resetVector)
    for (int c = 1; c < 8; c++) pdown(c[2:0], c[0]);
    enterPd(3'h7);
    wdog();
    // crystal was off in deep power down, so the oscillator wait comes first
    @(negedge clk);
    `CHK("sfrInit wait", 1'b0, sfrInit)
    waitFetch(VEC_ROM, 1'b0);
    `CHK("powerDownLevel", 3'h0, powerDownLevel)
    rd(ADDR_RESET_CAUSE, 8'h01, 8'h01);
    repeat (4) @(posedge clk);
    end_sim();
  end
endmodule
